// [hdl/pbm_map.svh]
// Constants for the burst output gate and byte write mask block.
`ifndef PBM_MAP_SVH
`define PBM_MAP_SVH

`define PBM_WORD_W     32
`define PBM_ADDR_W     22
`define PBM_LANE_W     8
`define PBM_LANES      4
`define PBM_BURST_LEN  8
`define PBM_BEAT_W     3
`define PBM_READ_LAT   4
`define PBM_WRITE_LAT  3
`define PBM_CNT_W      4
`define PBM_WORD_RST   32'h0000_0000
`define PBM_ADDR_RST   22'h00_0000

`endif

// [hdl/pbm_pkg.sv]
// Types shared by the burst output gate and byte write mask block.
`default_nettype none
`include "pbm_map.svh"

package pbm_pkg;

  typedef enum logic [1:0] {
    PBM_IDLE,
    PBM_WAIT,
    PBM_READ,
    PBM_WRITE
  } pbm_state_type;

  typedef logic [`PBM_WORD_W-1:0] pbm_word_type;
  typedef logic [`PBM_LANES-1:0]  pbm_mask_type;
  typedef logic [`PBM_ADDR_W-1:0] pbm_addr_type;

endpackage : pbm_pkg

`default_nettype wire

// [hdl/pbm_stream_if.sv]
// Valid/ready word stream between the fetch stage, buffer and output stage.
`timescale 1ns/1ps
`default_nettype none

interface pbm_stream_if #(parameter int WIDTH = 32);
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : pbm_stream_if

`default_nettype wire

// [hdl/pbm_pair_buf.sv]
// Two-entry buffer with valid and ready on both sides.
`timescale 1ns/1ps
`default_nettype none

module pbm_pair_buf #(
  parameter int WIDTH = 32
) (
  input  wire logic   sys_clk_i,
  input  wire logic   rst_i,
  pbm_stream_if.snk   fill,
  pbm_stream_if.src   drain
);

  logic [WIDTH-1:0] slot_ff [2];
  logic             rd_ptr_ff;
  logic             wr_ptr_ff;
  logic [1:0]       count_ff;
  wire              push;
  wire              pop;

  assign push        = fill.valid & fill.ready;
  assign pop         = drain.valid & drain.ready;
  assign fill.ready  = (count_ff != 2'h2);
  assign drain.valid = (count_ff != 2'h0);
  assign drain.data  = slot_ff[rd_ptr_ff];

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      slot_ff[0] <= '0;
      slot_ff[1] <= '0;
      rd_ptr_ff  <= 1'b0;
      wr_ptr_ff  <= 1'b0;
      count_ff   <= 2'h0;
    end else begin
      if (push) begin
        slot_ff[wr_ptr_ff] <= fill.data;
        wr_ptr_ff          <= ~wr_ptr_ff;
      end
      if (pop) begin
        rd_ptr_ff <= ~rd_ptr_ff;
      end
      count_ff <= count_ff + {1'b0, push} - {1'b0, pop};
    end
  end

endmodule : pbm_pair_buf

`default_nettype wire

// [hdl/pbm_top.sv]
// Burst read output gating and byte-masked burst writes of a small RAM.
`timescale 1ns/1ps
`default_nettype none
`include "pbm_map.svh"

module pbm_top #(
  parameter int MEM_AW    = 5,
  parameter int READ_LAT  = `PBM_READ_LAT,
  parameter int WRITE_LAT = `PBM_WRITE_LAT
) (
  input  wire logic              sys_clk_i,
  input  wire logic              rst_i,
  input  wire logic              chip_select_n_i,
  input  wire logic              addr_valid_n_i,
  input  wire logic              write_sel_n_i,
  input  wire logic              out_enable_n_i,
  input  wire pbm_pkg::pbm_mask_type byte_write_mask_i,
  input  wire pbm_pkg::pbm_word_type dq_i,
  output var  pbm_pkg::pbm_word_type dq_o,
  output var  logic              dq_oe_o,
  output var  logic              burst_busy_o
);
  import pbm_pkg::*;

  localparam int DEPTH = 1 << MEM_AW;

  // Two-flop synchronisers for all pin inputs.
  logic         cs_n_m_ff, cs_n_s_ff;
  logic         vld_n_m_ff, vld_n_s_ff;
  logic         we_n_m_ff, we_n_s_ff;
  logic         oe_n_m_ff, oe_n_s_ff;
  pbm_mask_type mask_m_ff, mask_s_ff;
  pbm_word_type dq_m_ff, dq_s_ff;

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cs_n_m_ff  <= 1'b1;
      cs_n_s_ff  <= 1'b1;
      vld_n_m_ff <= 1'b1;
      vld_n_s_ff <= 1'b1;
      we_n_m_ff  <= 1'b1;
      we_n_s_ff  <= 1'b1;
      oe_n_m_ff  <= 1'b1;
      oe_n_s_ff  <= 1'b1;
      mask_m_ff  <= 4'hF;
      mask_s_ff  <= 4'hF;
      dq_m_ff    <= `PBM_WORD_RST;
      dq_s_ff    <= `PBM_WORD_RST;
    end else begin
      cs_n_m_ff  <= chip_select_n_i;
      cs_n_s_ff  <= cs_n_m_ff;
      vld_n_m_ff <= addr_valid_n_i;
      vld_n_s_ff <= vld_n_m_ff;
      we_n_m_ff  <= write_sel_n_i;
      we_n_s_ff  <= we_n_m_ff;
      oe_n_m_ff  <= out_enable_n_i;
      oe_n_s_ff  <= oe_n_m_ff;
      mask_m_ff  <= byte_write_mask_i;
      mask_s_ff  <= mask_m_ff;
      dq_m_ff    <= dq_i;
      dq_s_ff    <= dq_m_ff;
    end
  end

  // Keeps a masked lane's old byte and takes the new byte elsewhere.
  function automatic pbm_word_type lane_merge(
    input pbm_word_type old_w,
    input pbm_word_type new_w,
    input pbm_mask_type mask
  );
    pbm_word_type res;
    res = old_w;
    for (int i = 0; i < `PBM_LANES; i++) begin
      if (!mask[i]) begin
        res[i*`PBM_LANE_W +: `PBM_LANE_W] =
          new_w[i*`PBM_LANE_W +: `PBM_LANE_W];
      end
    end
    return res;
  endfunction : lane_merge

  // Control state.
  pbm_state_type              state_ff, nxt_state;
  logic                       vld_seen_ff;
  logic                       is_write_ff;
  pbm_addr_type               addr_ff;
  logic [`PBM_CNT_W-1:0]      wait_cnt_ff, nxt_wait_cnt;
  logic [`PBM_BEAT_W-1:0]     beat_ff, nxt_beat;
  logic [`PBM_BEAT_W:0]       done_ff, nxt_done;
  pbm_word_type               mem_ff [DEPTH];
  pbm_word_type               dq_out_ff;
  logic                       dq_oe_ff;
  logic                       busy_ff;

  pbm_stream_if #(.WIDTH(`PBM_WORD_W)) fetch_s ();
  pbm_stream_if #(.WIDTH(`PBM_WORD_W)) out_s ();

  wire               sel_act;
  wire               capture;
  wire [MEM_AW-1:0]  mem_idx;
  wire               in_read;
  wire               in_write;
  wire               last_beat;
  wire               fetch_go;
  wire               mem_we;
  wire pbm_word_type mem_old;
  wire               pop;

  assign sel_act  = ~cs_n_s_ff;
  // First edge with valid and select low, once per valid pulse.
  assign capture  = sel_act & ~vld_n_s_ff & ~vld_seen_ff;
  // Linear burst wraps within the eight-word group.
  assign mem_idx  = {addr_ff[MEM_AW-1:`PBM_BEAT_W],
                     addr_ff[`PBM_BEAT_W-1:0] + beat_ff};
  assign in_read  = (state_ff == PBM_READ);
  assign in_write = (state_ff == PBM_WRITE);
  assign mem_old  = mem_ff[mem_idx];
  // A full buffer stalls the fetch without losing a beat.
  assign fetch_go = in_read & fetch_s.ready;
  assign mem_we   = in_write & sel_act;
  assign last_beat = (done_ff == 4'(`PBM_BURST_LEN - 1));
  assign fetch_s.valid = fetch_go;
  assign fetch_s.data  = mem_old;
  assign out_s.ready   = 1'b1;
  assign pop           = out_s.valid & out_s.ready;

  pbm_pair_buf #(.WIDTH(`PBM_WORD_W)) u_buf (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .fill      (fetch_s),
    .drain     (out_s)
  );

  always_comb begin
    nxt_state    = state_ff;
    nxt_wait_cnt = wait_cnt_ff;
    nxt_beat     = beat_ff;
    nxt_done     = done_ff;
    case (state_ff)
      PBM_IDLE: begin
      end
      PBM_WAIT: begin
        if (wait_cnt_ff == '0) begin
          nxt_state = is_write_ff ? PBM_WRITE : PBM_READ;
          nxt_beat  = '0;
          nxt_done  = '0;
        end else begin
          nxt_wait_cnt = wait_cnt_ff - 1'b1;
        end
      end
      PBM_READ, PBM_WRITE: begin
        if (fetch_go || mem_we) begin
          nxt_beat = beat_ff + 1'b1;
          nxt_done = done_ff + 1'b1;
          if (last_beat) begin
            nxt_state = PBM_IDLE;
          end
        end
      end
      default: begin
        nxt_state = PBM_IDLE;
      end
    endcase
    if (!sel_act) begin
      nxt_state = PBM_IDLE;
    end
    if (capture) begin
      nxt_state    = PBM_WAIT;
      nxt_wait_cnt = is_write_cmd(we_n_s_ff);
    end
  end

  // Latency is picked from the command sampled at capture.
  function automatic logic [`PBM_CNT_W-1:0] is_write_cmd(input logic we_n);
    return we_n ? `PBM_CNT_W'(READ_LAT - 1) : `PBM_CNT_W'(WRITE_LAT - 1);
  endfunction : is_write_cmd

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_ff    <= PBM_IDLE;
      wait_cnt_ff <= '0;
      beat_ff     <= '0;
      done_ff     <= '0;
      busy_ff     <= 1'b0;
    end else begin
      state_ff    <= nxt_state;
      wait_cnt_ff <= nxt_wait_cnt;
      beat_ff     <= nxt_beat;
      done_ff     <= nxt_done;
      busy_ff     <= (nxt_state != PBM_IDLE);
    end
  end

  // Command and address capture.
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      vld_seen_ff <= 1'b0;
      is_write_ff <= 1'b0;
      addr_ff     <= `PBM_ADDR_RST;
    end else begin
      vld_seen_ff <= sel_act & ~vld_n_s_ff;
      if (capture) begin
        addr_ff     <= dq_s_ff[`PBM_ADDR_W-1:0];
        is_write_ff <= ~we_n_s_ff;
      end
    end
  end

  // Masked write: data and masks come from the same sampled edge.
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_ff[i] <= `PBM_WORD_RST;
      end
    end else if (mem_we) begin
      mem_ff[mem_idx] <= lane_merge(mem_old, dq_s_ff,
                                    mask_s_ff);
    end
  end

  // Output stage: enable sampled at the launching edge decides the drive.
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      dq_out_ff <= `PBM_WORD_RST;
      dq_oe_ff  <= 1'b0;
    end else begin
      dq_oe_ff <= pop & ~oe_n_s_ff & sel_act;
      if (pop && !oe_n_s_ff) begin
        dq_out_ff <= out_s.data;
      end
    end
  end

  assign dq_o         = dq_out_ff;
  assign dq_oe_o      = dq_oe_ff;
  assign burst_busy_o = busy_ff;

  oe_gate_a : assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    (pop && oe_n_s_ff) |=> (!dq_oe_o && $stable(dq_o)))
    else $error("word driven while output enable was high");

  oe_drive_a : assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    (pop && !oe_n_s_ff && sel_act) |=>
      (dq_oe_o && dq_o == $past(out_s.data)))
    else $error("scheduled read word not driven");

  oe_release_a : assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    (dq_oe_o && pop && oe_n_s_ff) |-> ##1 !dq_oe_o)
    else $error("due word driven after enable removal");

  oe_sample_a : assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    dq_oe_o |-> ($past(pop) && !$past(oe_n_s_ff)))
    else $error("drive not tied to sampled enable");

  read_nomask_a : assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    in_read |-> !mem_we)
    else $error("memory written during burst read");

  read_keep_a : assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    in_read |=> (mem_ff[$past(mem_idx)] == $past(mem_old)))
    else $error("memory word changed during burst read");

  lane_zero_a : assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    mem_we |=> (mem_ff[$past(mem_idx)][7:0] == ($past(mask_s_ff[0]) ?
      $past(mem_old[7:0]) : $past(dq_s_ff[7:0]))))
    else $error("lane 0 write does not follow its mask");

  lane_mid_a : assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    mem_we |=> (mem_ff[$past(mem_idx)][23:16] == ($past(mask_s_ff[2]) ?
      $past(mem_old[23:16]) : $past(dq_s_ff[23:16]))))
    else $error("lane 2 write does not follow its mask");

  lane_top_a : assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    mem_we |=> (mem_ff[$past(mem_idx)][31:24] == ($past(mask_s_ff[3]) ?
      $past(mem_old[31:24]) : $past(dq_s_ff[31:24]))))
    else $error("lane 3 write does not follow its mask");

  all_mask_a : assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    (mem_we && mask_s_ff == 4'hF) |=>
      (mem_ff[$past(mem_idx)] == $past(mem_old)))
    else $error("fully masked write changed the word");

  addr_cap_a : assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    capture |=> (addr_ff == $past(dq_s_ff[21:0]) && state_ff == PBM_WAIT))
    else $error("address not captured on first valid edge");

  cmd_hold_a : assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    (!capture && state_ff != PBM_IDLE) |=> $stable(is_write_ff))
    else $error("command changed after capture");

  cmd_route_a : assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    (state_ff == PBM_WAIT && wait_cnt_ff == '0 && sel_act && !capture) |=>
      (is_write_ff ? in_write : in_read))
    else $error("burst kind does not follow captured command");

endmodule : pbm_top

`default_nettype wire

// [dv/pbm_ctl_model.sv]
// Memory controller model that drives the burst pins of the RAM block.
`timescale 1ns/1ps
`default_nettype none

module pbm_ctl_model (
  input  wire logic                  sys_clk_i,
  output var  logic                  chip_select_n_o,
  output var  logic                  addr_valid_n_o,
  output var  logic                  write_sel_n_o,
  output var  logic                  out_enable_n_o,
  output var  pbm_pkg::pbm_mask_type byte_write_mask_o,
  output var  pbm_pkg::pbm_word_type dq_o
);
  import pbm_pkg::*;

  initial begin
    chip_select_n_o   = 1'b1;
    addr_valid_n_o    = 1'b1;
    write_sel_n_o     = 1'b1;
    out_enable_n_o    = 1'b1;
    byte_write_mask_o = 4'hF;
    dq_o              = 32'h0000_0000;
  end

  // Returns on the edge that samples the address; the bus then shows junk.
  task automatic open_burst(input pbm_word_type a, input logic wr_n);
    @(posedge sys_clk_i);
    chip_select_n_o <= 1'b0;
    addr_valid_n_o  <= 1'b0;
    write_sel_n_o   <= wr_n;
    dq_o            <= a;
    @(posedge sys_clk_i);
    addr_valid_n_o <= 1'b1;
    write_sel_n_o  <= 1'b0;
    dq_o           <= ~a;
  endtask : open_burst

  task automatic put_beats(input pbm_word_type d [8],
                           input pbm_mask_type m [8]);
    repeat (2) @(posedge sys_clk_i);
    for (int i = 0; i < 8; i++) begin
      @(posedge sys_clk_i);
      dq_o              <= d[i];
      byte_write_mask_o <= m[i];
    end
    @(posedge sys_clk_i);
    dq_o              <= ~d[7];
    byte_write_mask_o <= 4'hF;
  endtask : put_beats

  task automatic gate_beats(input logic [7:0] g);
    repeat (4) @(posedge sys_clk_i);
    for (int i = 0; i < 8; i++) begin
      @(posedge sys_clk_i);
      out_enable_n_o    <= g[i];
      byte_write_mask_o <= 4'h0;
    end
    @(posedge sys_clk_i);
    out_enable_n_o    <= 1'b1;
    byte_write_mask_o <= 4'hF;
  endtask : gate_beats

  task automatic close_burst();
    repeat (6) @(posedge sys_clk_i);
    chip_select_n_o <= 1'b1;
    repeat (4) @(posedge sys_clk_i);
  endtask : close_burst
endmodule : pbm_ctl_model

`default_nettype wire

// [dv/testbench.sv]
// Self-checking bench for burst read gating and masked burst writes.
`timescale 1ns/1ps
`default_nettype none

module testbench;
  import pbm_pkg::*;

  logic         sys_clk_i;
  logic         rst_i;
  logic         cs_n;
  logic         vld_n;
  logic         we_n;
  logic         oe_n;
  pbm_mask_type mask;
  pbm_word_type dq_in;
  pbm_word_type dq_out;
  logic         dq_oe;
  logic         busy;
  pbm_word_type mem_m [32] = '{default: 32'h0000_0000};
  int           bad_count;
  int           checks;

  pbm_top #(.MEM_AW(5), .READ_LAT(4), .WRITE_LAT(3)) pbm_top_inst (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .chip_select_n_i(cs_n),
    .addr_valid_n_i(vld_n), .write_sel_n_i(we_n), .out_enable_n_i(oe_n),
    .byte_write_mask_i(mask), .dq_i(dq_in), .dq_o(dq_out),
    .dq_oe_o(dq_oe), .burst_busy_o(busy));

  pbm_ctl_model pbm_ctl_model_inst (
    .sys_clk_i(sys_clk_i), .chip_select_n_o(cs_n), .addr_valid_n_o(vld_n),
    .write_sel_n_o(we_n), .out_enable_n_o(oe_n),
    .byte_write_mask_o(mask), .dq_o(dq_in));

  always #10 sys_clk_i = ~sys_clk_i;

  function automatic int idx(input pbm_word_type a, input int i);
    return {a[4:3], 3'(a[2:0] + 3'(i))};
  endfunction : idx

  task automatic cmp_word(input pbm_word_type got, input pbm_word_type exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp_word

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : give_verdict

  task automatic do_write(input pbm_word_type a, input pbm_word_type d [8],
                          input pbm_mask_type m [8]);
    pbm_ctl_model_inst.open_burst(a, 1'b0);
    pbm_ctl_model_inst.put_beats(d, m);
    pbm_ctl_model_inst.close_burst();
    for (int i = 0; i < 8; i++)
      for (int l = 0; l < 4; l++)
        if (!m[i][l]) mem_m[idx(a, i)][8*l+:8] = d[i][8*l+:8];
  endtask : do_write

  // A set bit of g keeps output enable high for that beat.
  task automatic do_read(input pbm_word_type a, input logic [7:0] g);
    pbm_word_type got [$];
    int           n;
    int           nb;
    n  = 0;
    nb = 0;
    pbm_ctl_model_inst.open_burst(a, 1'b1);
    fork
      begin
        pbm_ctl_model_inst.gate_beats(g);
        pbm_ctl_model_inst.close_burst();
      end
      repeat (24) begin
        @(negedge sys_clk_i);
        if (dq_oe === 1'b1) got.push_back(dq_out);
        if (busy === 1'b1) nb++;
      end
    join
    for (int i = 0; i < 8; i++)
      if (!g[i]) begin
        if (n < got.size()) cmp_word(got[n], mem_m[idx(a, i)]);
        n++;
      end
    cmp_word(32'(got.size()), 32'(n));
    // Four wait cycles and eight beats, whatever the enable does.
    cmp_word(32'(nb), 32'(4 + 8));
    cmp_word(32'(busy), 32'h0000_0000);
  endtask : do_read

  task automatic sc_full();
    pbm_word_type d [8];
    pbm_mask_type m [8];
    for (int i = 0; i < 8; i++) begin
      d[i] = 32'h3C5A_9610 + 32'(i) * 32'h0101_0101;
      m[i] = 4'h0;
    end
    do_write(32'h0000_000B, d, m);
    do_read(32'h0000_000B, 8'h00);
  endtask : sc_full

  task automatic sc_mask();
    pbm_word_type d [8];
    pbm_mask_type m [8];
    m = '{4'h0, 4'hF, 4'hE, 4'hD, 4'hB, 4'h7, 4'h1, 4'hA};
    for (int i = 0; i < 8; i++) d[i] = 32'hC3A5_690F ^ 32'(i << 4);
    do_write(32'h0000_000B, d, m);
    do_read(32'h0000_000B, 8'h00);
  endtask : sc_mask

  task automatic sc_late_enable();
    do_read(32'h0000_0009, 8'h1F);
  endtask : sc_late_enable

  task automatic sc_early_off();
    do_read(32'h0000_000E, 8'hF0);
    cmp_word(dq_out, mem_m[idx(32'h0000_000E, 3)]);
    cmp_word(32'(dq_oe), 32'h0000_0000);
  endtask : sc_early_off

  initial begin
    sys_clk_i = 1'b0;
    rst_i     = 1'b1;
    bad_count = 0;
    checks    = 0;
    repeat (3) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    @(negedge sys_clk_i);
    cmp_word(32'(dq_oe), 32'h0000_0000);
    do_read(32'h0000_0014, 8'h00);
    sc_full();
    sc_mask();
    sc_late_enable();
    sc_early_off();
    give_verdict();
  end

  // Each burst takes under 40 cycles; this limit leaves a wide margin.
  initial begin
    #60000;
    bad_count++;
    give_verdict();
  end
endmodule : testbench

`default_nettype wire
